// ---- aoc_ctrl_status.sv ----
// Add-on general control/status register and bus-master transfer counts.
//
// How it works
// - Memory writes: low address, high address, data.
// - Go bit set; two bits pick the action.
// - Bit 28 makes transfer counts govern transfers.
// - Bit 27 write pulses mailbox flags empty.
// - Bit 26 write pulses inbound FIFO flag reset.
// - Bit 25 write pulses outbound FIFO flag reset.
// - Flag reset bits are write-only, read zero.
// - Bits 23:16 carry the memory port byte.
// - Completed read places fetched byte in field, unless a lane 2 write lands in the same cycle.
// - Bits 15:12 drive the self-test code.
// - Bits 7,6 flag zero counts when mastering.
// - Bits 5..3 show inbound FIFO state.
// - Bits 2..0 show outbound FIFO state.
// - Count registers accessible only while mastering enabled.
// - Write count drops with each master write.
// - Read count drops with each master read.
// - Zero count stops transfer, may interrupt.
// - Count not a multiple of four ends with partial word.
// - Counts are 26 bits, upper six zero.
`timescale 1ns/10ps
module aoc_ctrl_status
	import aoc_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// Add-on register port
	input  wire logic [7:0]  ab_addr,
	input  wire logic [3:0]  ab_be,
	input  wire logic        ab_wr,
	input  wire logic        ab_rd,
	input  wire logic [31:0] ab_wdata,
	output logic [31:0]      ab_rdata,
	// Mode and FIFO state
	input  wire logic        addon_bm_enable,
	input  wire logic        ififo_empty,
	input  wire logic        ififo_four_free,
	input  wire logic        ififo_full,
	input  wire logic        ofifo_empty,
	input  wire logic        ofifo_four_held,
	input  wire logic        ofifo_full,
	// Flag reset pulses and self-test code
	output logic             mbox_flag_rst,
	output logic             ififo_flag_rst,
	output logic             ofifo_flag_rst,
	output logic [3:0]       bist_code,
	// Bus-master engine
	input  wire logic        bm_wr_cycle,
	input  wire logic        bm_rd_cycle,
	output logic             xfer_count_en,
	output logic [3:0]       wr_byte_en,
	output logic [3:0]       rd_byte_en,
	output logic             wr_count_zero,
	output logic             rd_count_zero,
	output logic             wr_done,
	output logic             rd_done,
	// External memory pins
	output logic [15:0]      nv_addr,
	output logic [7:0]       nv_data_out,
	output logic             nv_data_oe_n,
	input  wire logic [7:0]  nv_data_in,
	output logic             nv_we_n,
	output logic             nv_oe_n
);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	wire         sel_gcs   = (ab_addr == GCS_OFFSET);
	wire         sel_wrc   = (ab_addr == WR_COUNT_OFFSET) && addon_bm_enable;
	wire         sel_rdc   = (ab_addr == RD_COUNT_OFFSET) && addon_bm_enable;
	wire         wr_gcs    = ab_wr && sel_gcs;
	wire         lane3_wr  = wr_gcs && ab_be[3];
	wire         lane2_wr  = wr_gcs && ab_be[2];
	wire         lane1_wr  = wr_gcs && ab_be[1];
	wire         full_wr   = (ab_be == 4'hf);
	wire         wrc_load  = ab_wr && sel_wrc && full_wr;
	wire         rdc_load  = ab_wr && sel_rdc && full_wr;

	// ----------------------------------------------------------------
	// Control storage
	// ----------------------------------------------------------------
	logic                   xfer_en_reg;
	logic [3:0]             bist_reg;
	aoc_nv_cmd_type         nv_cmd_reg;
	logic [7:0]             nv_wbyte_reg;
	logic                   nv_go_reg;
	logic                   mbox_rst_reg;
	logic                   ififo_rst_reg;
	logic                   ofifo_rst_reg;
	logic [31:0]            rdata_reg;
	logic [COUNT_WIDTH-1:0] wr_count;
	logic [COUNT_WIDTH-1:0] rd_count;

	wire nv_busy;
	wire nv_start = lane3_wr && ab_wdata[NV_GO_BIT] && !nv_busy && !nv_go_reg;
	logic nv_rd_pend_reg;
	wire  nv_done_rd = nv_rd_pend_reg && !nv_busy && !nv_go_reg;

	aoc_nv_if nv_bus ();

	always_ff @(posedge clk) begin
		if (srst) begin
			xfer_en_reg <= 1'b0;
		end else if (lane3_wr) begin
			xfer_en_reg <= ab_wdata[XFER_CNT_EN_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			bist_reg <= BIST_RESET;
		end else if (lane1_wr) begin
			bist_reg <= ab_wdata[BIST_CODE_LSB +: 4];
		end
	end

	// Byte for the memory port; a finished read replaces it unless a lane 2 write lands in the same cycle.
	always_ff @(posedge clk) begin
		if (srst) begin
			nv_wbyte_reg <= NV_BYTE_RESET;
		end else if (lane2_wr) begin
			nv_wbyte_reg <= ab_wdata[NV_BYTE_LSB +: 8];
		end else if (nv_done_rd) begin
			nv_wbyte_reg <= nv_bus.rbyte;
		end
	end

	// ----------------------------------------------------------------
	// External memory command launch
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			nv_go_reg <= 1'b0;
			nv_cmd_reg <= NV_LOAD_LO;
			nv_rd_pend_reg <= 1'b0;
		end else begin
			nv_go_reg <= nv_start;
			if (nv_start) begin
				nv_cmd_reg <= aoc_nv_cmd_type'(ab_wdata[NV_CMD_LO_BIT +: 2]);
			end
			if (nv_start && ab_wdata[NV_CMD_HI_BIT] && ab_wdata[NV_CMD_LO_BIT]) begin
				nv_rd_pend_reg <= 1'b1;
			end else if (nv_done_rd) begin
				nv_rd_pend_reg <= 1'b0;
			end
		end
	end

	assign nv_bus.go    = nv_go_reg;
	assign nv_bus.cmd   = nv_cmd_reg;
	// The port takes the byte a cycle after the go write, so a later bus write must not reach it.
	assign nv_bus.wbyte = nv_wbyte_reg;
	assign nv_busy      = nv_bus.busy;

	aoc_nv_port u_nv_port (
		.clk          (clk),
		.srst         (srst),
		.req          (nv_bus.port),
		.nv_addr      (nv_addr),
		.nv_data_out  (nv_data_out),
		.nv_data_oe_n (nv_data_oe_n),
		.nv_data_in   (nv_data_in),
		.nv_we_n      (nv_we_n),
		.nv_oe_n      (nv_oe_n)
	);

	// ----------------------------------------------------------------
	// Flag reset pulses
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			mbox_rst_reg <= 1'b0;
			ififo_rst_reg <= 1'b0;
			ofifo_rst_reg <= 1'b0;
		end else begin
			mbox_rst_reg <= lane3_wr && ab_wdata[MBOX_RST_BIT];
			ififo_rst_reg <= lane3_wr && ab_wdata[IFIFO_RST_BIT];
			ofifo_rst_reg <= lane3_wr && ab_wdata[OFIFO_RST_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Transfer counters
	// ----------------------------------------------------------------
	wire cnt_active = xfer_en_reg && addon_bm_enable;

	aoc_xfer_count #(.CW(COUNT_WIDTH)) u_wr_count (
		.clk      (clk),
		.srst     (srst),
		.load     (wrc_load),
		.load_val (ab_wdata[COUNT_WIDTH-1:0]),
		.count_en (cnt_active),
		.xfer     (bm_wr_cycle),
		.count    (wr_count),
		.zero     (wr_count_zero),
		.byte_en  (wr_byte_en),
		.done     (wr_done)
	);

	aoc_xfer_count #(.CW(COUNT_WIDTH)) u_rd_count (
		.clk      (clk),
		.srst     (srst),
		.load     (rdc_load),
		.load_val (ab_wdata[COUNT_WIDTH-1:0]),
		.count_en (cnt_active),
		.xfer     (bm_rd_cycle),
		.count    (rd_count),
		.zero     (rd_count_zero),
		.byte_en  (rd_byte_en),
		.done     (rd_done)
	);

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	wire        nv_state_bit = nv_busy || nv_go_reg;
	wire [7:0]  status_low = {
		addon_bm_enable && wr_count_zero,
		addon_bm_enable && rd_count_zero,
		ififo_empty,
		ififo_four_free,
		ififo_full,
		ofifo_empty,
		ofifo_four_held,
		ofifo_full
	};
	// Bits 27:25 and the reserved fields read back as zero.
	wire [31:0] gcs_value = {nv_state_bit, nv_cmd_reg, xfer_en_reg, 3'b000, 1'b0,
		nv_wbyte_reg, bist_reg, 4'h0, status_low};
	wire [31:0] wrc_value = {{(32-COUNT_WIDTH){1'b0}}, wr_count};
	wire [31:0] rdc_value = {{(32-COUNT_WIDTH){1'b0}}, rd_count};
	wire [31:0] rd_mux    = sel_gcs ? gcs_value :
	                        sel_wrc ? wrc_value :
	                        sel_rdc ? rdc_value : 32'h0000_0000;

	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_reg <= 32'h0000_0000;
		end else if (ab_rd) begin
			rdata_reg <= rd_mux;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign ab_rdata       = rdata_reg;
	assign mbox_flag_rst  = mbox_rst_reg;
	assign ififo_flag_rst = ififo_rst_reg;
	assign ofifo_flag_rst = ofifo_rst_reg;
	assign bist_code      = bist_reg;
	assign xfer_count_en  = xfer_en_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_nv_start_busy;
		@(posedge clk) disable iff (srst)
		nv_start |=> nv_go_reg ##1 (nv_busy || nv_cmd_reg == NV_LOAD_LO || nv_cmd_reg == NV_LOAD_HI);
	endproperty
	a_nv_start_busy: assert property (p_nv_start_busy) else $error("memory access not begun");

	property p_nv_busy_ignore;
		@(posedge clk) disable iff (srst)
		(lane3_wr && nv_busy) |-> !nv_start;
	endproperty
	a_nv_busy_ignore: assert property (p_nv_busy_ignore) else $error("access started while busy");

	property p_mbox_pulse;
		@(posedge clk) disable iff (srst)
		(lane3_wr && ab_wdata[MBOX_RST_BIT]) ##1 !(lane3_wr && ab_wdata[MBOX_RST_BIT])
			|-> mbox_flag_rst ##1 !mbox_flag_rst;
	endproperty
	a_mbox_pulse: assert property (p_mbox_pulse) else $error("mailbox reset not one shot");

	property p_ififo_pulse;
		@(posedge clk) disable iff (srst)
		$rose(ififo_flag_rst) |-> $past(lane3_wr) && $past(ab_wdata[IFIFO_RST_BIT]);
	endproperty
	a_ififo_pulse: assert property (p_ififo_pulse) else $error("inbound reset without write");

	property p_ofifo_pulse;
		@(posedge clk) disable iff (srst)
		(lane3_wr && ab_wdata[OFIFO_RST_BIT]) |=> ofifo_flag_rst;
	endproperty
	a_ofifo_pulse: assert property (p_ofifo_pulse) else $error("outbound reset missing");

	property p_reset_bits_zero;
		@(posedge clk) disable iff (srst)
		(ab_rd && sel_gcs) |=> ab_rdata[27:25] == 3'b000 && ab_rdata[24] == 1'b0;
	endproperty
	a_reset_bits_zero: assert property (p_reset_bits_zero) else $error("write-only bits read back");

	property p_bist;
		@(posedge clk) disable iff (srst)
		lane1_wr |=> bist_code == $past(ab_wdata[15:12]);
	endproperty
	a_bist: assert property (p_bist) else $error("self-test code not applied");

	property p_zero_flags;
		@(posedge clk) disable iff (srst)
		(ab_rd && sel_gcs) |=> ab_rdata[7] == $past(addon_bm_enable && wr_count_zero)
			&& ab_rdata[6] == $past(addon_bm_enable && rd_count_zero);
	endproperty
	a_zero_flags: assert property (p_zero_flags) else $error("zero count flags wrong");

	property p_fifo_live;
		@(posedge clk) disable iff (srst)
		(ab_rd && sel_gcs) |=> ab_rdata[5:0] == $past({ififo_empty, ififo_four_free, ififo_full,
			ofifo_empty, ofifo_four_held, ofifo_full});
	endproperty
	a_fifo_live: assert property (p_fifo_live) else $error("fifo flags not live");

	property p_count_gate;
		@(posedge clk) disable iff (srst)
		(ab_rd && !addon_bm_enable && ab_addr != GCS_OFFSET) |=> ab_rdata == 32'h0000_0000;
	endproperty
	a_count_gate: assert property (p_count_gate) else $error("count readable while disabled");

	property p_count_upper;
		@(posedge clk) disable iff (srst)
		(ab_rd && (sel_wrc || sel_rdc)) |=> ab_rdata[31:26] == 6'h00;
	endproperty
	a_count_upper: assert property (p_count_upper) else $error("reserved count bits set");

	property p_count_hold;
		@(posedge clk) disable iff (srst)
		(!cnt_active && !wrc_load) |=> wr_count == $past(wr_count);
	endproperty
	a_count_hold: assert property (p_count_hold) else $error("count moved while disabled");

	property p_read_result;
		@(posedge clk) disable iff (srst)
		(nv_done_rd && !lane2_wr) |=> nv_wbyte_reg == $past(nv_bus.rbyte);
	endproperty
	a_read_result: assert property (p_read_result) else $error("read byte not placed");

endmodule // aoc_ctrl_status

// ---- aoc_pkg.sv ----
// Shared constants for the add-on control, status and transfer-count block.
package aoc_pkg;

	// ----------------------------------------------------------------
	// Register offsets on the add-on bus
	// ----------------------------------------------------------------
	localparam logic [7:0] GCS_OFFSET      = 8'h3c;
	localparam logic [7:0] WR_COUNT_OFFSET = 8'h58;
	localparam logic [7:0] RD_COUNT_OFFSET = 8'h5c;

	// ----------------------------------------------------------------
	// Field positions of the general control and status register
	// ----------------------------------------------------------------
	localparam int NV_GO_BIT        = 31;
	localparam int NV_CMD_HI_BIT    = 30;
	localparam int NV_CMD_LO_BIT    = 29;
	localparam int XFER_CNT_EN_BIT  = 28;
	localparam int MBOX_RST_BIT     = 27;
	localparam int IFIFO_RST_BIT    = 26;
	localparam int OFIFO_RST_BIT    = 25;
	localparam int NV_BYTE_LSB      = 16;
	localparam int BIST_CODE_LSB    = 12;
	localparam int WR_ZERO_BIT      = 7;
	localparam int RD_ZERO_BIT      = 6;
	localparam int IFIFO_EMPTY_BIT  = 5;
	localparam int IFIFO_4FREE_BIT  = 4;
	localparam int IFIFO_FULL_BIT   = 3;
	localparam int OFIFO_EMPTY_BIT  = 2;
	localparam int OFIFO_4HELD_BIT  = 1;
	localparam int OFIFO_FULL_BIT   = 0;

	// ----------------------------------------------------------------
	// Counts, reset values and timing
	// ----------------------------------------------------------------
	localparam int          COUNT_WIDTH    = 26;
	localparam int          WORD_BYTES     = 4;
	localparam logic [31:0] COUNT_RESET    = 32'h0000_0000;
	localparam logic [3:0]  BIST_RESET     = 4'h0;
	localparam logic [7:0]  NV_BYTE_RESET  = 8'h00;
	localparam int          CLK_MHZ        = 25;
	localparam int          NV_ACCESS_NS   = 240;
	localparam int          NV_ACCESS_CYC  = (NV_ACCESS_NS * CLK_MHZ + 999) / 1000;

	// ----------------------------------------------------------------
	// External memory port commands
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		NV_LOAD_LO = 2'b00,
		NV_LOAD_HI = 2'b01,
		NV_WRITE   = 2'b10,
		NV_READ    = 2'b11
	} aoc_nv_cmd_type;

	typedef enum logic [1:0] {
		NV_IDLE   = 2'b00,
		NV_ACC_WR = 2'b01,
		NV_ACC_RD = 2'b10
	} aoc_nv_state_type;

endpackage

// ---- aoc_nv_if.sv ----
// Request and answer group between the register bank and the memory port.
`timescale 1ns/10ps
interface aoc_nv_if;
	logic                   go;
	aoc_pkg::aoc_nv_cmd_type cmd;
	logic [7:0]             wbyte;
	logic                   busy;
	logic [7:0]             rbyte;
	modport ctrl (output go, output cmd, output wbyte, input busy, input rbyte);
	modport port (input go, input cmd, input wbyte, output busy, output rbyte);
endinterface

// ---- aoc_nv_port.sv ----
// Byte-wide external non-volatile memory access sequencer.
`timescale 1ns/10ps
module aoc_nv_port
	import aoc_pkg::*;
(
	// Clock and reset
	input  wire logic  clk,
	input  wire logic  srst,
	// Request group
	aoc_nv_if.port     req,
	// Memory pins
	output logic [15:0] nv_addr,
	output logic [7:0]  nv_data_out,
	output logic        nv_data_oe_n,
	input  wire logic [7:0] nv_data_in,
	output logic        nv_we_n,
	output logic        nv_oe_n
);
	aoc_nv_state_type state_reg;
	logic [3:0]       cnt_reg;
	logic [7:0]       rbyte_reg;
	logic [7:0]       s1_reg, s2_reg, s3_reg;
	wire              acc_end  = (cnt_reg >= 4'(NV_ACCESS_CYC - 1));
	wire              rd_agree = (s2_reg == s3_reg);
	wire              take     = req.go && (state_reg == NV_IDLE);

	assign req.busy  = (state_reg != NV_IDLE);
	assign req.rbyte = rbyte_reg;

	always_ff @(posedge clk) begin
		s1_reg <= nv_data_in;
		s2_reg <= s1_reg;
		s3_reg <= s2_reg;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= NV_IDLE;
			cnt_reg <= 4'h0;
			rbyte_reg <= NV_BYTE_RESET;
			nv_addr <= 16'h0000;
			nv_data_out <= 8'h00;
			nv_data_oe_n <= 1'b1;
			nv_we_n <= 1'b1;
			nv_oe_n <= 1'b1;
		end else begin
			case (state_reg)
				NV_IDLE: begin
					cnt_reg <= 4'h0;
					if (take) begin
						case (req.cmd)
							NV_LOAD_LO: nv_addr[7:0] <= req.wbyte;
							NV_LOAD_HI: nv_addr[15:8] <= req.wbyte;
							NV_WRITE: begin
								nv_data_out <= req.wbyte;
								nv_data_oe_n <= 1'b0;
								nv_we_n <= 1'b0;
								state_reg <= NV_ACC_WR;
							end
							default: begin
								nv_oe_n <= 1'b0;
								state_reg <= NV_ACC_RD;
							end
						endcase
					end
				end
				NV_ACC_WR: begin
					cnt_reg <= cnt_reg + 4'h1;
					if (acc_end) begin
						nv_we_n <= 1'b1;
						nv_data_oe_n <= 1'b1;
						state_reg <= NV_IDLE;
					end
				end
				NV_ACC_RD: begin
					if (!acc_end) begin
						cnt_reg <= cnt_reg + 4'h1;
					end else if (rd_agree) begin
						rbyte_reg <= s3_reg;
						nv_oe_n <= 1'b1;
						state_reg <= NV_IDLE;
					end
				end
				default: state_reg <= NV_IDLE;
			endcase
		end
	end

	property p_write_len;
		@(posedge clk) disable iff (srst)
		(take && req.cmd == NV_WRITE) |=> !nv_we_n [*6] ##1 nv_we_n;
	endproperty
	a_write_len: assert property (p_write_len) else $error("write strobe length wrong");

endmodule // aoc_nv_port

// ---- aoc_xfer_count.sv ----
// Down-counting bus-master byte count with partial final word.
`timescale 1ns/10ps
module aoc_xfer_count
	import aoc_pkg::*;
#(
	parameter int CW = COUNT_WIDTH
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          srst,
	// Software load
	input  wire logic          load,
	input  wire logic [CW-1:0] load_val,
	// Bus-master engine
	input  wire logic          count_en,
	input  wire logic          xfer,
	output logic [CW-1:0]      count,
	output logic               zero,
	output logic [3:0]         byte_en,
	output logic               done
);
	wire            step_ok   = count_en && xfer && !zero;
	wire [CW-1:0]   step      = (count >= CW'(WORD_BYTES)) ? CW'(WORD_BYTES) : count;
	wire [CW-1:0]   cnt_next  = load ? load_val : (step_ok ? count - step : count);
	wire [3:0]      be_next   = (cnt_next >= CW'(WORD_BYTES)) ? 4'hf :
	                            (cnt_next == CW'(3)) ? 4'h7 :
	                            (cnt_next == CW'(2)) ? 4'h3 :
	                            (cnt_next == CW'(1)) ? 4'h1 : 4'h0;

	always_ff @(posedge clk) begin
		if (srst) begin
			count <= CW'(COUNT_RESET);
			zero <= 1'b1;
			byte_en <= 4'h0;
			done <= 1'b0;
		end else begin
			count <= cnt_next;
			zero <= (cnt_next == '0);
			byte_en <= be_next;
			done <= step_ok && !load && (count == step);
		end
	end

	property p_step;
		@(posedge clk) disable iff (srst)
		(step_ok && !load && count > CW'(WORD_BYTES)) |=> count == $past(count) - CW'(WORD_BYTES);
	endproperty
	a_step: assert property (p_step) else $error("count did not drop by one word");

	property p_done;
		@(posedge clk) disable iff (srst)
		(step_ok && !load && count <= CW'(WORD_BYTES)) |=> done && zero ##1 !done;
	endproperty
	a_done: assert property (p_done) else $error("terminal count not flagged");

	property p_partial;
		@(posedge clk) disable iff (srst)
		(count == CW'(3)) |-> byte_en == 4'h7;
	endproperty
	a_partial: assert property (p_partial) else $error("partial word enables wrong");

endmodule // aoc_xfer_count

// ---- aoc_nv_mem_model.sv ----
// Byte-wide external memory model on the far side of the memory pins.
`timescale 1ns/10ps
module aoc_nv_mem_model (
	// Clock
	input  wire logic        clk,
	// Memory pins
	input  wire logic [15:0] nv_addr,
	input  wire logic [7:0]  nv_data_out,
	input  wire logic        nv_data_oe_n,
	input  wire logic        nv_we_n,
	input  wire logic        nv_oe_n,
	output logic [7:0]       nv_data_in
);
	logic [7:0] mem [0:255];
	logic [7:0] last_q;

	// A released data bus shows the inverse of its last value, not a stale copy.
	always_comb nv_data_in = !nv_oe_n ? mem[nv_addr[7:0]] : ~last_q;

	always_ff @(posedge clk) begin
		if (!nv_we_n && !nv_data_oe_n) begin
			mem[nv_addr[7:0]] <= nv_data_out;
		end
		if (!nv_oe_n) begin
			last_q <= mem[nv_addr[7:0]];
		end
	end
endmodule // aoc_nv_mem_model

// ---- aoc_ctrl_status_tb_top.sv ----
// Self-checking testbench of the add-on control, status and count block.
`timescale 1ns/10ps
module aoc_ctrl_status_tb_top;
	import aoc_pkg::*;
	logic        clk, srst, ab_wr, ab_rd, addon_bm_enable, bm_wr_cycle, bm_rd_cycle;
	logic        ififo_empty, ififo_four_free, ififo_full, ofifo_empty, ofifo_four_held, ofifo_full;
	logic        mbox_flag_rst, ififo_flag_rst, ofifo_flag_rst, xfer_count_en;
	logic        wr_count_zero, rd_count_zero, wr_done, rd_done, nv_data_oe_n, nv_we_n, nv_oe_n;
	logic [3:0]  ab_be, bist_code, wr_byte_en, rd_byte_en;
	logic [7:0]  ab_addr, nv_data_out, nv_data_in, ca;
	logic [15:0] nv_addr;
	logic [31:0] ab_wdata, ab_rdata, d;
	int          bad_count, comparisons;

	aoc_ctrl_status dut (.clk, .srst, .ab_addr, .ab_be, .ab_wr, .ab_rd, .ab_wdata, .ab_rdata,
		.addon_bm_enable, .ififo_empty, .ififo_four_free, .ififo_full, .ofifo_empty,
		.ofifo_four_held, .ofifo_full, .mbox_flag_rst, .ififo_flag_rst, .ofifo_flag_rst,
		.bist_code, .bm_wr_cycle, .bm_rd_cycle, .xfer_count_en, .wr_byte_en, .rd_byte_en,
		.wr_count_zero, .rd_count_zero, .wr_done, .rd_done, .nv_addr, .nv_data_out,
		.nv_data_oe_n, .nv_data_in, .nv_we_n, .nv_oe_n);
	aoc_nv_mem_model mem (.clk, .nv_addr, .nv_data_out, .nv_data_oe_n, .nv_we_n, .nv_oe_n, .nv_data_in);

	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	task chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] v);
		@(posedge clk);
		ab_addr <= a; ab_be <= b; ab_wdata <= v; ab_wr <= 1'b1;
		@(posedge clk);
		ab_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk);
		ab_addr <= a; ab_rd <= 1'b1;
		@(posedge clk);
		ab_rd <= 1'b0;
		#1 d = ab_rdata;
	endtask
	task bm(input bit s);
		@(posedge clk);
		bm_wr_cycle <= !s; bm_rd_cycle <= s;
		@(posedge clk);
		bm_wr_cycle <= 1'b0; bm_rd_cycle <= 1'b0;
		#1;
	endtask
	// Issues one memory port command, then polls the busy bit with a bound.
	task nv(input logic [1:0] c, input logic [7:0] b);
		wr(GCS_OFFSET, 4'hc, {1'b1, c, 5'h00, b, 16'h0000});
		for (int n = 0; n < 40; n++) begin
			rd(GCS_OFFSET);
			if (d[31] === 1'b0) break;
		end
		chk(d[31], 0);
	endtask

	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		tally_and_finish;
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		bad_count = 0; comparisons = 0;
		srst = 1; ab_wr = 0; ab_rd = 0; ab_addr = 0; ab_be = 0; ab_wdata = 0;
		addon_bm_enable = 0; bm_wr_cycle = 0; bm_rd_cycle = 0;
		{ififo_empty, ififo_four_free, ififo_full, ofifo_empty, ofifo_four_held, ofifo_full} = 6'h34;
		repeat (12) @(posedge clk);
		srst <= 0;
		rd(GCS_OFFSET);
		chk(d, 32'h0000_0034);
		addon_bm_enable <= 1;
		rd(GCS_OFFSET);
		chk(d, 32'h0000_00f4);
		for (int i = 0; i < 6; i++) begin
			{ififo_empty, ififo_four_free, ififo_full, ofifo_empty, ofifo_four_held, ofifo_full} <= 6'h20 >> i;
			rd(GCS_OFFSET);
			chk(d, 32'hc0 | (32'h20 >> i));
		end
		$display("status test done");
		for (int i = 0; i < 3; i++) begin
			wr(GCS_OFFSET, 4'h8, 32'h1 << (27 - i));
			#1 chk({mbox_flag_rst, ififo_flag_rst, ofifo_flag_rst}, 3'b100 >> i);
			@(posedge clk);
			#1 chk({mbox_flag_rst, ififo_flag_rst, ofifo_flag_rst}, 0);
			rd(GCS_OFFSET);
			chk(d[27:24], 0);
		end
		wr(GCS_OFFSET, 4'h2, 32'h0000_a000);
		#1 chk(bist_code, 4'ha);
		rd(GCS_OFFSET);
		chk(d[15:12], 4'ha);
		$display("flag reset and self-test code test done");
		for (int s = 0; s < 2; s++) begin
			ca = s ? RD_COUNT_OFFSET : WR_COUNT_OFFSET;
			addon_bm_enable <= 0;
			wr(ca, 4'hf, 32'h6);
			rd(ca);
			chk(d, 0);
			addon_bm_enable <= 1;
			wr(ca, 4'hf, 32'hffff_ffff);
			rd(ca);
			chk(d, 32'h03ff_ffff);
			wr(ca, 4'hf, 32'h6);
			wr(GCS_OFFSET, 4'h8, 32'h0);
			#1 chk(xfer_count_en, 0);
			bm(s);
			rd(ca);
			chk(d, 32'h6);
			wr(GCS_OFFSET, 4'h8, 32'h1000_0000);
			#1 chk(xfer_count_en, 1);
			// The engine model starts every transfer on a word boundary.
			bm(s);
			chk(s ? rd_byte_en : wr_byte_en, 4'h3);
			rd(ca);
			chk(d, 32'h2);
			bm(s);
			chk(s ? {rd_count_zero, rd_done} : {wr_count_zero, wr_done}, 2'b11);
			@(posedge clk);
			#1 chk(s ? rd_done : wr_done, 0);
		end
		$display("transfer count test done");
		// Only the add-on side touches the memory here, so no access overlaps.
		nv(NV_LOAD_LO, 8'h12);
		nv(NV_LOAD_HI, 8'h00);
		chk(nv_addr, 16'h0012);
		nv(NV_WRITE, 8'h5a);
		nv(NV_READ, 8'h00);
		rd(GCS_OFFSET);
		chk(d[23:16], 8'h5a);
		$display("memory port test done");
		tally_and_finish;
	end
endmodule // aoc_ctrl_status_tb_top
